// ===== plc_task_scheduler.sv
// Priority task dispatcher with Wishbone register access
//
// The register offsets and the Wishbone register port were decided locally.
`timescale 1ns/1ps
module plc_task_scheduler #(
  parameter int MS_CYCLES  = plc_sched_pkg::MS_CYCLES_DEF,
  parameter int EXT_CYCLES = plc_sched_pkg::EXT_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic [11:0] adr_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  input  wire logic        we_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic             ack_o,
  // CPU state
  input  wire logic        run_mode_i,
  input  wire logic        init_busy_i,
  input  wire logic        scan_end_i,
  // Trigger sources
  input  wire logic [7:0]  ext_in_i,
  input  wire logic [7:0]  bool_var_i,
  input  wire logic [31:0] hs_count_i,
  // Dispatch outputs
  output logic             task_start_o,
  output logic      [4:0]  start_task_o,
  output logic             running_valid_o,
  output logic      [4:0]  running_task_o,
  output logic             task_collision_flag_o,
  output logic             cfg_error_o
);
  import plc_sched_pkg::*;

  typedef struct packed {
    logic                     ack;
    logic [31:0]              dat;
    logic [NTASK-1:0]         pend;
    logic [NTASK-1:0]         act;
    cfg_arr_t                 cfg;
    logic [NPER-1:0][31:0]    cyc;
    logic [NPER-1:0][31:0]    per_cnt;
    logic [NLOG-1:0][31:0]    collision_time_log;
    logic [NLOG-1:0]          collision_bitmap;
    logic                     task_collision_flag;
    logic                     starts_en;
    logic [31:0]              counter_match_value;
    logic                     armed;
    logic [31:0]              ms_time;
    logic [7:0]               ext_prev;
    logic [7:0]               int_prev;
    logic                     run_valid;
    logic [4:0]               run_task;
    logic                     start;
    logic [4:0]               start_task;
    logic                     cfg_err;
  } sched_state_t;

  sched_state_t s_r, s_nxt;
  logic         ms_tick, ext_tick, step_tick;
  logic         pend_v, act_v;
  logic [2:0]   pend_lvl, act_lvl;
  logic [7:0]   pend_mask, act_mask;

  // Level occupied by any enabled task of a vector
  function automatic logic [7:0] lvl_mask(input logic [NTASK-1:0] v, input cfg_arr_t c);
    logic [7:0] m;
    m = 8'h0;
    for (int t = 0; t < NTASK; t++)
      if (v[t] && c[t][CFG_EN_BIT])
        m[c[t][CFG_LVL_LSB +: 3]] = 1'b1;
    return m;
  endfunction : lvl_mask

  // Task of a vector that sits on a given level
  function automatic logic [4:0] task_at(input logic [NTASK-1:0] v, input cfg_arr_t c,
                                          input logic [2:0] l);
    logic [4:0] r;
    r = 5'h0;
    for (int t = 0; t < NTASK; t++)
      if (v[t] && c[t][CFG_EN_BIT] && c[t][CFG_LVL_LSB +: 3] == l)
        r = 5'(t);
    return r;
  endfunction : task_at

  // Byte-lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] sl);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++)
      if (sl[b])
        r[8*b +: 8] = d[8*b +: 8];
    return r;
  endfunction : merge

  // Time bases
  sched_tick_gen #(
    .MS_CYCLES  (MS_CYCLES),
    .EXT_CYCLES (EXT_CYCLES)
  ) u_tick (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .run_i       (run_mode_i),
    .ms_tick_o   (ms_tick),
    .ext_tick_o  (ext_tick),
    .step_tick_o (step_tick)
  );

  // Most urgent pending and most urgent started levels
  assign pend_mask = lvl_mask(s_r.pend, s_r.cfg);
  assign act_mask  = lvl_mask(s_r.act, s_r.cfg);
  sched_prio_pick u_pick_pend (
    .vec_i   (pend_mask),
    .valid_o (pend_v),
    .lvl_o   (pend_lvl)
  );
  sched_prio_pick u_pick_act (
    .vec_i   (act_mask),
    .valid_o (act_v),
    .lvl_o   (act_lvl)
  );

  // Next-state logic
  always_comb
  begin
    logic              hit;
    logic              wr;
    logic [11:0]       a;
    logic [NTASK-1:0]  req;
    logic [7:0]        occ;
    logic [2:0]        sel;
    logic [2:0]        lv;
    logic              go;
    logic [4:0]        gt;
    hit = cyc_i & stb_i;
    wr  = hit & s_r.ack & we_i;
    a   = adr_i & 12'hffc;
    req = '0;
    occ = 8'h0;
    sel = 3'h0;
    lv  = 3'h0;
    go  = 1'b0;
    gt  = 5'h0;
    s_nxt       = s_r;
    s_nxt.start = 1'b0;
    // Bus: ack one cycle after request, drop the cycle after
    s_nxt.ack = hit & ~s_r.ack;
    s_nxt.dat = 32'h0;
    if (hit && !s_r.ack && !we_i)
    begin
      if (a == REG_CTRL)
        s_nxt.dat[CTRL_DIS_BIT] = ~s_r.starts_en;
      else if (a == REG_STATUS)
      begin
        s_nxt.dat[ST_COLL_BIT]          = s_r.task_collision_flag;
        s_nxt.dat[ST_CFGERR_BIT]        = s_r.cfg_err;
        s_nxt.dat[ST_RUNV_BIT]          = s_r.run_valid;
        s_nxt.dat[ST_TASK_LSB +: 5]     = s_r.run_task;
        s_nxt.dat[ST_STEN_BIT]          = s_r.starts_en;
        s_nxt.dat[ST_ARMED_BIT]         = s_r.armed;
      end
      else if (a == REG_BITMAP)
        s_nxt.dat[NLOG-1:0] = s_r.collision_bitmap;
      else if (a == REG_MATCH)
        s_nxt.dat = s_r.counter_match_value;
      else if (a == REG_TIME)
        s_nxt.dat = s_r.ms_time;
      for (int i = 0; i < NLOG; i++)
        if (a == REG_LOG_BASE + 12'(4 * i))
          s_nxt.dat = s_r.collision_time_log[i];
      for (int i = 0; i < NTASK; i++)
        if (a == REG_CFG_BASE + 12'(4 * i))
          s_nxt.dat[7:0] = s_r.cfg[i];
      for (int i = 0; i < NPER; i++)
        if (a == REG_CYC_BASE + 12'(4 * i))
          s_nxt.dat = s_r.cyc[i];
    end
    // Bus writes; unmapped offsets are acknowledged and ignored
    if (wr)
    begin
      if (a == REG_CTRL && sel_i[0])
      begin
        if (dat_i[CTRL_DIS_BIT])
          s_nxt.starts_en = 1'b0;
        if (dat_i[CTRL_EN_BIT])
          s_nxt.starts_en = 1'b1;
        if (dat_i[CTRL_DONE_BIT] && s_r.run_valid)
          s_nxt.act[s_r.run_task] = 1'b0;
      end
      else if (a == REG_STATUS && sel_i[0] && dat_i[ST_COLL_BIT])
        s_nxt.task_collision_flag = 1'b0;
      else if (a == REG_BITMAP)
        s_nxt.collision_bitmap = s_r.collision_bitmap & ~(dat_i[NLOG-1:0] & {{8{sel_i[1]}}, {8{sel_i[0]}}});
      else if (a == REG_MATCH)
      begin
        s_nxt.counter_match_value = merge(s_r.counter_match_value, dat_i, sel_i);
        s_nxt.armed               = 1'b1;
      end
      for (int i = 0; i < NTASK; i++)
        if (a == REG_CFG_BASE + 12'(4 * i) && sel_i[0])
          s_nxt.cfg[i] = dat_i[7:0];
      for (int i = 0; i < NPER; i++)
        if (a == REG_CYC_BASE + 12'(4 * i))
          s_nxt.cyc[i] = merge(s_r.cyc[i], dat_i, sel_i);
    end
    // Scan end restores task starts
    if (scan_end_i)
      s_nxt.starts_en = 1'b1;
    // Millisecond time stamp for collision logging
    if (ms_tick)
      s_nxt.ms_time = s_r.ms_time + 32'h1;
    // Periodic timers, stepped only in run mode
    for (int i = 0; i < NPER; i++)
      if (step_tick && run_mode_i && s_r.cfg[PER_BASE + i][CFG_EN_BIT])
      begin
        if (s_r.per_cnt[i] + 32'h1 >= s_r.cyc[i])
        begin
          s_nxt.per_cnt[i]    = 32'h0;
          req[PER_BASE + i]   = 1'b1;
        end
        else
          s_nxt.per_cnt[i] = s_r.per_cnt[i] + 32'h1;
      end
    // External inputs: edge against previous sample, run mode only
    if (ext_tick)
    begin
      s_nxt.ext_prev = ext_in_i;
      for (int i = 0; i < NEXT; i++)
      begin
        sel = s_r.cfg[EXT_BASE + i][CFG_SEL_LSB +: 3];
        if (ext_in_i[sel] && !s_r.ext_prev[sel] && run_mode_i &&
            s_r.cfg[EXT_BASE + i][CFG_EN_BIT])
          req[EXT_BASE + i] = 1'b1;
      end
    end
    // Internal variables checked once the scan program finishes
    if (scan_end_i)
    begin
      s_nxt.int_prev = bool_var_i;
      for (int i = 0; i < NINT; i++)
        if (run_mode_i && s_r.cfg[INT_BASE + i][CFG_EN_BIT] && bool_var_i[i] &&
            (s_r.cfg[INT_BASE + i][CFG_LEVEL_BIT] || !s_r.int_prev[i]))
          req[INT_BASE + i] = 1'b1;
    end
    // High-speed count match, fires once per loaded value
    if (s_r.armed && run_mode_i && hs_count_i == s_r.counter_match_value &&
        s_r.cfg[HS_TASK][CFG_EN_BIT])
    begin
      req[HS_TASK] = 1'b1;
      s_nxt.armed  = 1'b0;
    end
    // Queue requests; a busy task drops the repeat, logged only for tasks below NLOG
    for (int t = 0; t < NTASK; t++)
      if (req[t])
      begin
        if (s_r.pend[t] || s_r.act[t])
        begin
          if (t < NLOG)
          begin
            s_nxt.task_collision_flag   = 1'b1;
            s_nxt.collision_bitmap[t]   = 1'b1;
            s_nxt.collision_time_log[t] = s_r.ms_time;
          end
        end
        else
          s_nxt.pend[t] = 1'b1;
      end
    // Duplicate level check over enabled tasks
    s_nxt.cfg_err = 1'b0;
    for (int t = 0; t < NTASK; t++)
      if (s_r.cfg[t][CFG_EN_BIT])
      begin
        lv = s_r.cfg[t][CFG_LVL_LSB +: 3];
        if (occ[lv])
          s_nxt.cfg_err = 1'b1;
        occ[lv] = 1'b1;
      end
    // Dispatch most urgent pending over running task or scan; clash checked on this cycle's table
    go = pend_v && (!act_v || pend_lvl < act_lvl) &&
         !init_busy_i && s_r.starts_en && !s_nxt.cfg_err &&
         run_mode_i;
    if (go)
    begin
      gt                = task_at(s_r.pend, s_r.cfg, pend_lvl);
      s_nxt.pend[gt]    = 1'b0;
      s_nxt.act[gt]     = 1'b1;
      s_nxt.start       = 1'b1;
      s_nxt.start_task  = gt;
    end
    // Running task is the most urgent started one
    s_nxt.run_valid = act_v;
    s_nxt.run_task  = task_at(s_r.act, s_r.cfg, act_lvl);
  end
  // State register with reset values
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_r                     <= '0;
      s_r.starts_en           <= 1'b1;
      s_r.cfg                 <= {NTASK{CFG_RST}};
      s_r.cyc                 <= {NPER{CYC_RST}};
      s_r.counter_match_value <= MATCH_RST;
    end
    else
      s_r <= s_nxt;
  end

  // Outputs
  assign dat_o                 = s_r.dat;
  assign ack_o                 = s_r.ack;
  assign task_start_o          = s_r.start;
  assign start_task_o          = s_r.start_task;
  assign running_valid_o       = s_r.run_valid;
  assign running_task_o        = s_r.run_task;
  assign task_collision_flag_o = s_r.task_collision_flag;
  assign cfg_error_o           = s_r.cfg_err;
endmodule : plc_task_scheduler

// ===== plc_sched_pkg.sv
// Shared constants and types for the task dispatcher
package plc_sched_pkg;
  // Task population and index layout
  localparam int NTASK    = 25;
  localparam int NLVL     = 8;
  localparam int NPER     = 8;
  localparam int NEXT     = 8;
  localparam int NINT     = 8;
  localparam int NLOG     = 16;
  localparam int PER_BASE = 0;
  localparam int EXT_BASE = 8;
  localparam int INT_BASE = 16;
  localparam int HS_TASK  = 24;

  // Timing
  localparam int CLK_PERIOD_NS  = 8;
  localparam int MS_PERIOD_NS   = 1000000;
  localparam int EXT_DETECT_NS  = 400000;
  localparam int MS_CYCLES_DEF  = MS_PERIOD_NS / CLK_PERIOD_NS;
  localparam int EXT_CYCLES_DEF = EXT_DETECT_NS / CLK_PERIOD_NS;
  localparam int STEP_MS        = 10;

  // Register byte offsets
  localparam logic [11:0] REG_CTRL     = 12'h000;
  localparam logic [11:0] REG_STATUS   = 12'h004;
  localparam logic [11:0] REG_BITMAP   = 12'h008;
  localparam logic [11:0] REG_MATCH    = 12'h00c;
  localparam logic [11:0] REG_TIME     = 12'h010;
  localparam logic [11:0] REG_LOG_BASE = 12'h040;
  localparam logic [11:0] REG_CFG_BASE = 12'h100;
  localparam logic [11:0] REG_CYC_BASE = 12'h200;

  // Field positions
  localparam int CTRL_DIS_BIT  = 0;
  localparam int CTRL_EN_BIT   = 1;
  localparam int CTRL_DONE_BIT = 2;
  localparam int ST_COLL_BIT   = 0;
  localparam int ST_CFGERR_BIT = 1;
  localparam int ST_RUNV_BIT   = 2;
  localparam int ST_TASK_LSB   = 3;
  localparam int ST_STEN_BIT   = 8;
  localparam int ST_ARMED_BIT  = 9;
  localparam int CFG_EN_BIT    = 0;
  localparam int CFG_LVL_LSB   = 1;
  localparam int CFG_LEVEL_BIT = 4;
  localparam int CFG_SEL_LSB   = 5;

  // Reset values
  localparam logic [7:0]  CFG_RST   = 8'h00;
  localparam logic [31:0] CYC_RST   = 32'h0000_0001;
  localparam logic [31:0] MATCH_RST = 32'h0000_0000;

  typedef logic [NTASK-1:0][7:0] cfg_arr_t;
endpackage : plc_sched_pkg

// ===== sched_tick_gen.sv
// Millisecond, input-sample and 10 ms step tick generator
`timescale 1ns/1ps
module sched_tick_gen #(
  parameter int MS_CYCLES  = plc_sched_pkg::MS_CYCLES_DEF,
  parameter int EXT_CYCLES = plc_sched_pkg::EXT_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Mode
  input  wire logic run_i,
  // Ticks
  output logic      ms_tick_o,
  output logic      ext_tick_o,
  output logic      step_tick_o
);
  import plc_sched_pkg::*;

  typedef struct packed {
    logic [31:0] ms_cnt;
    logic [31:0] ext_cnt;
    logic [7:0]  step_cnt;
    logic        ms;
    logic        ext;
    logic        step;
  } tick_state_t;

  tick_state_t s_r, s_nxt;

  // Counters; step prescaler only advances in run mode
  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.ms   = 1'b0;
    s_nxt.ext  = 1'b0;
    s_nxt.step = 1'b0;
    if (s_r.ms_cnt >= 32'(MS_CYCLES - 1))
    begin
      s_nxt.ms_cnt = 32'h0;
      s_nxt.ms     = 1'b1;
    end
    else
      s_nxt.ms_cnt = s_r.ms_cnt + 32'h1;
    if (s_r.ext_cnt >= 32'(EXT_CYCLES - 1))
    begin
      s_nxt.ext_cnt = 32'h0;
      s_nxt.ext     = 1'b1;
    end
    else
      s_nxt.ext_cnt = s_r.ext_cnt + 32'h1;
    if (s_r.ms && run_i)
    begin
      if (s_r.step_cnt >= 8'(STEP_MS - 1))
      begin
        s_nxt.step_cnt = 8'h0;
        s_nxt.step     = 1'b1;
      end
      else
        s_nxt.step_cnt = s_r.step_cnt + 8'h1;
    end
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign ms_tick_o   = s_r.ms;
  assign ext_tick_o  = s_r.ext;
  assign step_tick_o = s_r.step;
endmodule : sched_tick_gen

// ===== sched_prio_pick.sv
// Picks the most urgent (lowest) set level of an 8-level vector
`timescale 1ns/1ps
module sched_prio_pick (
  // Level request vector
  input  wire logic [7:0] vec_i,
  // Result
  output logic            valid_o,
  output logic [2:0]      lvl_o
);
  // Scan from least urgent so the lowest index wins
  always_comb
  begin
    valid_o = 1'b0;
    lvl_o   = 3'h0;
    for (int l = 7; l >= 0; l--)
    begin
      if (vec_i[l])
      begin
        valid_o = 1'b1;
        lvl_o   = 3'(l);
      end
    end
  end
endmodule : sched_prio_pick

// ===== plc_task_scheduler_chk.sv
// Port-level assertions for the task dispatcher
`timescale 1ns/1ps
module plc_task_scheduler_chk
  import plc_sched_pkg::*;
(
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Bus
  input wire logic [11:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic        we_i,
  input wire logic [3:0]  sel_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  // CPU state and dispatch
  input wire logic        run_mode_i,
  input wire logic        init_busy_i,
  input wire logic        scan_end_i,
  input wire logic        task_start_o,
  input wire logic [4:0]  start_task_o,
  input wire logic        running_valid_o,
  input wire logic        task_collision_flag_o,
  input wire logic        cfg_error_o
);
  logic wr_ok;
  logic done_w;
  logic dis_r;
  // Accepted lane-0 writes
  assign wr_ok  = cyc_i && stb_i && we_i && ack_o && sel_i[0];
  assign done_w = wr_ok && adr_i == REG_CTRL && dat_i[CTRL_DONE_BIT];
  // Mirror of start disable; scan end wins
  always_ff @(posedge clk_i)
    if (rst_i) dis_r <= 1'b0;
    else if (scan_end_i || (wr_ok && adr_i == REG_CTRL && dat_i[CTRL_EN_BIT])) dis_r <= 1'b0;
    else if (wr_ok && adr_i == REG_CTRL && dat_i[CTRL_DIS_BIT]) dis_r <= 1'b1;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  init_holds_a : assert property (task_start_o |-> !$past(init_busy_i))
    else $error("start during initialization");
  disable_holds_a : assert property (task_start_o |-> !$past(dis_r) || $past(scan_end_i))
    else $error("start while starts disabled");
  run_gate_a : assert property (task_start_o |-> $past(run_mode_i))
    else $error("start outside run mode");
  cfg_err_block_a : assert property (cfg_error_o && $past(cfg_error_o) |-> !task_start_o)
    else $error("start with level clash");
  scan_preempt_a : assert property (task_start_o |=> running_valid_o)
    else $error("start without running task");
  start_idx_hold_a : assert property (!task_start_o |-> $stable(start_task_o))
    else $error("start index moved without start");
  coll_sticky_a : assert property ($fell(task_collision_flag_o) |->
    $past(wr_ok && adr_i == REG_STATUS && dat_i[ST_COLL_BIT]))
    else $error("collision flag dropped by itself");
  resume_end_a : assert property ($fell(running_valid_o) |-> $past(done_w) || $past(done_w, 2))
    else $error("running ended without task done");
endmodule : plc_task_scheduler_chk

bind plc_task_scheduler plc_task_scheduler_chk plc_task_scheduler_chk_i (
  .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .we_i(we_i), .sel_i(sel_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .run_mode_i(run_mode_i),
  .init_busy_i(init_busy_i), .scan_end_i(scan_end_i), .task_start_o(task_start_o),
  .start_task_o(start_task_o), .running_valid_o(running_valid_o),
  .task_collision_flag_o(task_collision_flag_o), .cfg_error_o(cfg_error_o));

// ===== contact_model.sv
// Model of the eight discrete input contacts
`timescale 1ns/1ps
module contact_model #(
  parameter int HOLD = 12
) (
  // Clock
  input  wire logic       clk_i,
  // Edge requests, one per contact
  input  wire logic [7:0] fire_i,
  // Contact levels
  output logic      [7:0] ext_o
);
  int cnt [8] = '{default: 0};
  // A request closes the contact for HOLD cycles
  always_ff @(posedge clk_i)
    for (int k = 0; k < 8; k++) // only eight contacts exist
    begin
      if (fire_i[k]) cnt[k] <= HOLD;
      else if (cnt[k] > 0) cnt[k] <= cnt[k] - 1;
    end
  // Rising edge at closure, long enough for sampling
  always_comb
    for (int k = 0; k < 8; k++)
      ext_o[k] = (cnt[k] != 0);
endmodule : contact_model

// ===== tb_plc_task_scheduler.sv
// Self-checking bench for the task dispatcher
`timescale 1ns/1ps
module tb_plc_task_scheduler;
  import plc_sched_pkg::*;
  logic        clk_i = 0;
  logic        rst_i = 1;
  logic [11:0] adr_i = '0;
  logic [31:0] dat_i = '0;
  logic        we_i = 0;
  logic [3:0]  sel_i = '0;
  logic        cyc_i = 0;
  logic        stb_i = 0;
  logic        run_mode_i = 1;
  logic        init_busy_i = 0;
  logic        scan_end_i = 0;
  logic [7:0]  fire = '0;
  logic [7:0]  ext_in_i;
  logic [7:0]  bool_var_i = '0;
  logic [31:0] hs_count_i = '0;
  logic [31:0] dat_o;
  logic [31:0] rd;
  logic        ack_o;
  logic        task_start_o;
  logic        running_valid_o;
  logic        task_collision_flag_o;
  logic        cfg_error_o;
  logic [4:0]  start_task_o;
  logic [4:0]  running_task_o;
  int          err_total = 0;
  int          n_compared = 0;
  int          ticks = 0;

  plc_task_scheduler #(.MS_CYCLES(10), .EXT_CYCLES(4)) plc_task_scheduler_i (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i),
    .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .run_mode_i(run_mode_i),
    .init_busy_i(init_busy_i), .scan_end_i(scan_end_i), .ext_in_i(ext_in_i),
    .bool_var_i(bool_var_i), .hs_count_i(hs_count_i), .task_start_o(task_start_o),
    .start_task_o(start_task_o), .running_valid_o(running_valid_o),
    .running_task_o(running_task_o), .task_collision_flag_o(task_collision_flag_o),
    .cfg_error_o(cfg_error_o));
  contact_model contact_model_i (.clk_i(clk_i), .fire_i(fire), .ext_o(ext_in_i));

  // Clock, 8 ns period
  initial
    forever #4 clk_i = ~clk_i;

  // Hang guard
  always @(posedge clk_i)
  begin
    ticks <= ticks + 1;
    if (ticks == 20000)
    begin
      err_total++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : cmp

  // One classic bus cycle, held until ack
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 40);
    rd = dat_o;
    cmp(32'(ack_o), 32'h1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic cfg(input int i, input logic [7:0] v);
    wb(1'b1, REG_CFG_BASE + 12'(4 * i), 32'(v));
  endtask : cfg

  task automatic done;
    wb(1'b1, REG_CTRL, 32'h4);
  endtask : done

  task automatic pulse(input int k);
    fire[k] <= 1'b1;
    @(posedge clk_i);
    fire[k] <= 1'b0;
  endtask : pulse

  task automatic scan;
    scan_end_i <= 1'b1;
    @(posedge clk_i);
    scan_end_i <= 1'b0;
  endtask : scan

  // Wait for a start (or its absence) and check the index
  task automatic want(input logic ok, input logic [4:0] id, input int lim);
    int n;
    logic got;
    n = 0;
    got = 1'b0;
    while (!got && n < lim)
    begin
      @(posedge clk_i);
      n++;
      got = (task_start_o === 1'b1);
    end
    cmp(32'(got), 32'(ok));
    if (got) cmp(32'(start_task_o), 32'(id));
  endtask : want

  task automatic t_regs;
    wb(1'b0, REG_STATUS, 0);
    cmp(rd, 32'h100);
    wb(1'b0, REG_CYC_BASE, 0);
    cmp(rd, CYC_RST);
    wb(1'b1, 12'hffc, 32'hffff_ffff);
    wb(1'b0, 12'hffc, 0);
    cmp(rd, 32'h0);
    $display("end regs");
  endtask : t_regs

  task automatic t_ext;
    cfg(8, 8'h05);
    pulse(0);
    want(1'b1, 5'd8, 30);
    @(posedge clk_i); // Running flag lands one cycle after the start pulse
    cmp(32'(running_valid_o), 32'h1);
    repeat (20) @(posedge clk_i);
    pulse(0);
    want(1'b0, 5'd8, 20);
    cmp(32'(task_collision_flag_o), 32'h1);
    wb(1'b0, REG_BITMAP, 0);
    cmp(rd, 32'h100);
    wb(1'b1, REG_STATUS, 32'h1);
    wb(1'b1, REG_BITMAP, 32'h100);
    wb(1'b0, REG_STATUS, 0);
    cmp(rd, 32'h144);
    cfg(9, 8'ha7);
    pulse(5);
    want(1'b0, 5'd9, 30);
    done;
    want(1'b1, 5'd9, 10);
    done;
    cfg(9, 8'h00);
    repeat (3) @(posedge clk_i);
    cmp(32'(running_valid_o), 32'h0);
    $display("end ext");
  endtask : t_ext

  task automatic t_pre;
    pulse(0);
    want(1'b1, 5'd8, 30);
    cfg(0, 8'h01);
    want(1'b1, 5'd0, 130);
    repeat (110) @(posedge clk_i);
    wb(1'b0, REG_BITMAP, 0);
    cmp(rd, 32'h1);
    // Finish the pre-empting task first so the suspended one resumes
    done;
    repeat (3) @(posedge clk_i);
    cmp(32'(running_task_o), 32'd8);
    cfg(0, 8'h00);
    done;
    wb(1'b1, REG_STATUS, 32'h1);
    wb(1'b1, REG_BITMAP, 32'h1);
    $display("end preempt");
  endtask : t_pre

  task automatic t_block;
    for (int m = 0; m < 4; m++)
    begin
      if (m == 0) init_busy_i <= 1'b1;
      if (m == 1 || m == 3) wb(1'b1, REG_CTRL, 32'h1);
      if (m == 2) run_mode_i <= 1'b0;
      pulse(0);
      want(1'b0, 5'd8, 30);
      init_busy_i <= 1'b0;
      run_mode_i <= 1'b1;
      if (m == 1) scan;
      if (m == 3) wb(1'b1, REG_CTRL, 32'h2);
      want(m != 2, 5'd8, 30);
      if (m != 2) done;
      repeat (20) @(posedge clk_i);
    end
    $display("end block");
  endtask : t_block

  task automatic t_cfg;
    cfg(9, 8'h05);
    repeat (2) @(posedge clk_i);
    cmp(32'(cfg_error_o), 32'h1);
    pulse(0);
    want(1'b0, 5'd8, 30);
    cfg(9, 8'h00);
    want(1'b1, 5'd8, 10);
    done;
    $display("end cfg");
  endtask : t_cfg

  task automatic t_int;
    cfg(16, 8'h09);
    bool_var_i <= 8'h01;
    want(1'b0, 5'd16, 20);
    scan;
    want(1'b1, 5'd16, 10);
    done;
    scan;
    want(1'b0, 5'd16, 10);
    cfg(16, 8'h00);
    $display("end internal");
  endtask : t_int

  task automatic t_hs;
    cfg(24, 8'h0b);
    hs_count_i <= 32'd4;
    wb(1'b1, REG_MATCH, 32'd5);
    want(1'b0, 5'd24, 20);
    hs_count_i <= 32'd5;
    want(1'b1, 5'd24, 20);
    done;
    $display("end counter");
  endtask : t_hs

  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_ext();
    t_pre();
    t_block();
    t_cfg();
    t_int();
    t_hs();
    print_verdict();
  end
endmodule : tb_plc_task_scheduler
